// ==== src/dht_consts.vh ====
`ifndef DHT_CONSTS_VH
`define DHT_CONSTS_VH

// Register byte offsets.
`define DHT_OFF_CFG 8'h00
`define DHT_OFF_MODE_A 8'h04
`define DHT_OFF_MODE_B 8'h08
`define DHT_OFF_CTL 8'h0C
`define DHT_OFF_LOAD_A 8'h10
`define DHT_OFF_LOAD_B 8'h14
`define DHT_OFF_MATCH_A 8'h18
`define DHT_OFF_MATCH_B 8'h1C
`define DHT_OFF_PRE_A 8'h20
`define DHT_OFF_PRE_B 8'h24
`define DHT_OFF_VAL_A 8'h28
`define DHT_OFF_VAL_B 8'h2C
`define DHT_OFF_RIS 8'h30
`define DHT_OFF_IMR 8'h34
`define DHT_OFF_MIS 8'h38
`define DHT_OFF_ADC 8'h3C
`define DHT_OFF_SYNC 8'h40

// Global configuration fields.
`define DHT_CFG_JOIN 0
`define DHT_CFG_RTC 1
`define DHT_CFG_CLKSRC 2

// Per-half mode register fields.
`define DHT_M_MODE_LO 0
`define DHT_M_MODE_HI 1
`define DHT_M_UP 2
`define DHT_M_CAPTIME 3
`define DHT_M_EDGE_LO 4
`define DHT_M_EDGE_HI 5
`define DHT_M_INV 6
`define DHT_M_TRIG 7
`define DHT_M_STALL 8
`define DHT_M_ACT_LO 9
`define DHT_M_ACT_HI 11

// Operating modes of a half counter.
`define DHT_MODE_ONESHOT 2'h0
`define DHT_MODE_PERIODIC 2'h1
`define DHT_MODE_CAPTURE 2'h2
`define DHT_MODE_PWM 2'h3

// Capture edge selection.
`define DHT_EDGE_RISE 2'h0
`define DHT_EDGE_FALL 2'h1
`define DHT_EDGE_BOTH 2'h2

// Pin action on timeout.
`define DHT_ACT_NONE 3'h0
`define DHT_ACT_TOGGLE 3'h1
`define DHT_ACT_SET 3'h2
`define DHT_ACT_CLEAR 3'h3
`define DHT_ACT_SETTOG 3'h4

// Event bit positions in status, mask and converter-trigger registers.
`define DHT_EV_TIMEOUT 0
`define DHT_EV_CAPMATCH 1
`define DHT_EV_CAPEVENT 2
`define DHT_EV_MODEMATCH 3
`define DHT_EV_B_BASE 4
`define DHT_EV_RTC 8
`define DHT_EV_W 9

// Reset values.
`define DHT_RST_CFG 3'h0
`define DHT_RST_MODE 12'h000
`define DHT_RST_EV 9'h000

// Real-time clock input rate and one-second divider; half-counter and prescaler widths.
`define DHT_RTC_HZ 32768
`define DHT_HALF_W 16
`define DHT_PRE_W 8

`endif

// ==== src/dht_half.v ====
`timescale 1ns/1ps
`include "dht_consts.vh"

module dht_half #(
    parameter W = 16,
    parameter PW = 8
)(
    input wire i_clk,
    input wire i_rst,
    input wire i_en,
    input wire i_tick,
    input wire i_stall,
    input wire i_sync,
    input wire i_rtc,
    input wire [1:0] i_mode,
    input wire i_up,
    input wire i_cap_time,
    input wire [1:0] i_edge,
    input wire i_inv,
    input wire [2:0] i_act,
    input wire [PW-1:0] i_pre,
    input wire [W-1:0] i_load,
    input wire [W-1:0] i_match,
    input wire i_ccp,
    output wire [W-1:0] o_val,
    output wire o_timeout,
    output wire o_cap_match,
    output wire o_cap_event,
    output wire o_mode_match,
    output wire o_ccp,
    output wire o_ccp_oe
);

reg [W-1:0] cnt_q;
reg [W-1:0] cap_q;
reg [PW-1:0] pre_q;
reg done_q;
reg en_q;
reg ccp_prev_q;
reg act_q;

wire is_cap = (i_mode == `DHT_MODE_CAPTURE);
wire is_capc = is_cap & ~i_cap_time;
wire is_capt = is_cap & i_cap_time;
wire is_pwm = (i_mode == `DHT_MODE_PWM);
wire up = i_up & ~is_pwm;
wire [W-1:0] start = up ? {W{1'b0}} : i_load;
wire [W-1:0] stepped = up ? cnt_q + 1'b1 : cnt_q - 1'b1;
wire at_end = up ? (cnt_q == i_load) : (cnt_q == {W{1'b0}});
wire pre_run = i_en & i_tick & ~i_stall & ~done_q;
wire pre_done = (pre_q == i_pre);
wire step = pre_run & pre_done & ~is_capc;
wire rise = i_ccp & ~ccp_prev_q;
wire fall = ~i_ccp & ccp_prev_q;
wire edge_hit = i_en & ((i_edge == `DHT_EDGE_RISE) & rise
    | (i_edge == `DHT_EDGE_FALL) & fall
    | (i_edge == `DHT_EDGE_BOTH) & (rise | fall));

assign o_timeout = step & at_end & ~i_rtc;
assign o_mode_match = step & (cnt_q == i_match);
assign o_cap_event = edge_hit & is_cap;
assign o_cap_match = o_cap_event & is_capc & (stepped == i_match);
assign o_val = is_capt ? cap_q : cnt_q;
// Edge-aligned: high from reload down to one above the match value.
assign o_ccp = (is_pwm ? (cnt_q > i_match) : act_q) ^ i_inv;
assign o_ccp_oe = is_pwm | (~is_cap & (i_act != `DHT_ACT_NONE));

always @(posedge i_clk)
begin
    if (i_rst)
    begin
        cnt_q <= {W{1'b0}};
        cap_q <= {W{1'b0}};
        pre_q <= {PW{1'b0}};
        done_q <= 1'b0;
        en_q <= 1'b0;
        ccp_prev_q <= 1'b0;
        act_q <= 1'b0;
    end
    else
    begin
        en_q <= i_en;
        ccp_prev_q <= i_ccp;
        if (i_sync)
        begin
            cnt_q <= start;
            pre_q <= {PW{1'b0}};
        end
        else if (!i_en)
        begin
            pre_q <= {PW{1'b0}};
            done_q <= 1'b0;
            if (done_q)
                cnt_q <= start;
        end
        else
        begin
            if (pre_run)
                pre_q <= pre_done ? {PW{1'b0}} : pre_q + 1'b1;
            if (is_capc)
            begin
                if (edge_hit)
                    cnt_q <= stepped;
            end
            else if (step)
            begin
                if (at_end && !i_rtc)
                begin
                    if (i_mode == `DHT_MODE_ONESHOT)
                        done_q <= 1'b1;
                    else
                        cnt_q <= start;
                end
                else
                    cnt_q <= stepped;
            end
            if (is_capt && edge_hit)
                cap_q <= cnt_q;
        end
        // The set-then-toggle action presets the pin as the half starts.
        if (i_en && !en_q && i_act == `DHT_ACT_SETTOG)
            act_q <= 1'b1;
        else if (o_timeout)
        begin
            case (i_act)
                `DHT_ACT_TOGGLE: act_q <= ~act_q;
                `DHT_ACT_SET: act_q <= 1'b1;
                `DHT_ACT_CLEAR: act_q <= 1'b0;
                `DHT_ACT_SETTOG: act_q <= ~act_q;
                default: act_q <= act_q;
            endcase
        end
    end
end

endmodule // dht_half

// ==== src/dht_timer.v ====
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dht_consts.vh"

module dht_timer #(
    parameter HALF_W = `DHT_HALF_W,
    parameter PW = `DHT_PRE_W,
    parameter RTC_DIV = `DHT_RTC_HZ
)(
    input wire I_REF_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output wire O_PREADY,
    output wire O_PSLVERR,
    input wire I_OSC_CLK,
    input wire I_RTC_CLK,
    input wire I_DBG_HALT,
    input wire I_SYNC,
    output reg O_SYNC,
    input wire I_CCP_A,
    output wire O_CCP_A,
    output wire O_CCP_A_OE,
    input wire I_CCP_B,
    output wire O_CCP_B,
    output wire O_CCP_B_OE,
    output reg O_TRIG_A,
    output reg O_TRIG_B,
    output reg O_ADC_TRIG,
    output wire O_IRQ
);

localparam FW = 2 * HALF_W;
localparam EW = `DHT_EV_W;

reg [2:0] cfg_q;
reg [11:0] mode_a_q;
reg [11:0] mode_b_q;
reg [1:0] ctl_q;
reg [HALF_W-1:0] load_a_q;
reg [HALF_W-1:0] load_b_q;
reg [HALF_W-1:0] match_a_q;
reg [HALF_W-1:0] match_b_q;
reg [PW-1:0] pre_a_q;
reg [PW-1:0] pre_b_q;
reg [EW-1:0] ris_q;
reg [EW-1:0] imr_q;
reg [EW-1:0] adc_q;
reg [EW-1:0] rd_clr_q;
reg osc_prev_q;
reg rtc_prev_q;
reg [31:0] rtc_div_q;
reg [31:0] rd_d;

function is_mapped;
    input [7:0] a;
    begin
        is_mapped = (a[1:0] == 2'h0) && (a <= `DHT_OFF_SYNC);
    end
endfunction

wire setup = I_PSEL & ~I_PENABLE;
wire wr = I_PSEL & I_PENABLE & I_PWRITE & is_mapped(I_PADDR);
wire rd_setup = setup & ~I_PWRITE & is_mapped(I_PADDR);
assign O_PREADY = 1'b1;
assign O_PSLVERR = I_PSEL & I_PENABLE & ~is_mapped(I_PADDR);

wire joined = cfg_q[`DHT_CFG_JOIN];
wire rtc = joined & cfg_q[`DHT_CFG_RTC];
wire osc_edge = I_OSC_CLK & ~osc_prev_q;
wire base_tick = cfg_q[`DHT_CFG_CLKSRC] ? osc_edge : 1'b1;
wire rtc_edge = I_RTC_CLK & ~rtc_prev_q;
wire rtc_sec = rtc_edge & (rtc_div_q == RTC_DIV - 1);

// Capture and PWM codes fold onto the timer modes when joined.
wire [1:0] mode_a = joined ? {1'b0, mode_a_q[`DHT_M_MODE_LO]}
    : mode_a_q[`DHT_M_MODE_HI:`DHT_M_MODE_LO];
wire [FW-1:0] load_full = {load_b_q & {HALF_W{joined}}, load_a_q};
wire [FW-1:0] match_full = {match_b_q & {HALF_W{joined}}, match_a_q};
wire sync_all = I_SYNC | O_SYNC;

wire [FW-1:0] val_a;
wire [HALF_W-1:0] val_b;
wire a_to, a_cm, a_ce, a_mm;
wire b_to, b_cm, b_ce, b_mm;

dht_half #(.W(FW), .PW(PW)) u_first_half_counter (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_en(ctl_q[0]),
    .i_tick(rtc ? rtc_sec : base_tick),
    .i_stall(I_DBG_HALT & mode_a_q[`DHT_M_STALL]),
    .i_sync(sync_all),
    .i_rtc(rtc),
    .i_mode(mode_a),
    .i_up(mode_a_q[`DHT_M_UP] | rtc),
    .i_cap_time(mode_a_q[`DHT_M_CAPTIME]),
    .i_edge(mode_a_q[`DHT_M_EDGE_HI:`DHT_M_EDGE_LO]),
    .i_inv(mode_a_q[`DHT_M_INV]),
    .i_act(mode_a_q[`DHT_M_ACT_HI:`DHT_M_ACT_LO]),
    .i_pre(joined ? {PW{1'b0}} : pre_a_q),
    .i_load(load_full),
    .i_match(match_full),
    .i_ccp(I_CCP_A),
    .o_val(val_a),
    .o_timeout(a_to),
    .o_cap_match(a_cm),
    .o_cap_event(a_ce),
    .o_mode_match(a_mm),
    .o_ccp(O_CCP_A),
    .o_ccp_oe(O_CCP_A_OE)
);

dht_half #(.W(HALF_W), .PW(PW)) u_second_half_counter (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_en(ctl_q[1] & ~joined),
    .i_tick(base_tick),
    .i_stall(I_DBG_HALT & mode_b_q[`DHT_M_STALL]),
    .i_sync(sync_all),
    .i_rtc(1'b0),
    .i_mode(mode_b_q[`DHT_M_MODE_HI:`DHT_M_MODE_LO]),
    .i_up(mode_b_q[`DHT_M_UP]),
    .i_cap_time(mode_b_q[`DHT_M_CAPTIME]),
    .i_edge(mode_b_q[`DHT_M_EDGE_HI:`DHT_M_EDGE_LO]),
    .i_inv(mode_b_q[`DHT_M_INV]),
    .i_act(mode_b_q[`DHT_M_ACT_HI:`DHT_M_ACT_LO]),
    .i_pre(pre_b_q),
    .i_load(load_b_q),
    .i_match(match_b_q),
    .i_ccp(I_CCP_B),
    .o_val(val_b),
    .o_timeout(b_to),
    .o_cap_match(b_cm),
    .o_cap_event(b_ce),
    .o_mode_match(b_mm),
    .o_ccp(O_CCP_B),
    .o_ccp_oe(O_CCP_B_OE)
);

// In real-time clock mode a match is reported as the clock event only.
wire [EW-1:0] ev = {rtc & a_mm, b_mm, b_ce, b_cm, b_to,
    a_mm & ~rtc, a_ce, a_cm, a_to};
wire [EW-1:0] wr_clr = (wr && I_PADDR == `DHT_OFF_RIS)
    ? I_PWDATA[EW-1:0] : {EW{1'b0}};
wire rd_ris = I_PSEL & I_PENABLE & ~I_PWRITE & (I_PADDR == `DHT_OFF_RIS);
wire [EW-1:0] clr = wr_clr | (rd_ris ? rd_clr_q : {EW{1'b0}});

assign O_IRQ = |(ris_q & imr_q);

always @*
begin
    rd_d = 32'h00000000;
    if (I_PADDR == `DHT_OFF_CFG)
        rd_d[2:0] = cfg_q;
    else if (I_PADDR == `DHT_OFF_MODE_A)
        rd_d[11:0] = mode_a_q;
    else if (I_PADDR == `DHT_OFF_MODE_B)
        rd_d[11:0] = mode_b_q;
    else if (I_PADDR == `DHT_OFF_CTL)
        rd_d[1:0] = ctl_q;
    else if (I_PADDR == `DHT_OFF_LOAD_A)
        rd_d[HALF_W-1:0] = load_a_q;
    else if (I_PADDR == `DHT_OFF_LOAD_B)
        rd_d[HALF_W-1:0] = load_b_q;
    else if (I_PADDR == `DHT_OFF_MATCH_A)
        rd_d[HALF_W-1:0] = match_a_q;
    else if (I_PADDR == `DHT_OFF_MATCH_B)
        rd_d[HALF_W-1:0] = match_b_q;
    else if (I_PADDR == `DHT_OFF_PRE_A)
        rd_d[PW-1:0] = pre_a_q;
    else if (I_PADDR == `DHT_OFF_PRE_B)
        rd_d[PW-1:0] = pre_b_q;
    else if (I_PADDR == `DHT_OFF_VAL_A)
        rd_d[HALF_W-1:0] = val_a[HALF_W-1:0];
    else if (I_PADDR == `DHT_OFF_VAL_B)
        rd_d[HALF_W-1:0] = joined ? val_a[FW-1:HALF_W] : val_b;
    else if (I_PADDR == `DHT_OFF_RIS)
        rd_d[EW-1:0] = ris_q;
    else if (I_PADDR == `DHT_OFF_IMR)
        rd_d[EW-1:0] = imr_q;
    else if (I_PADDR == `DHT_OFF_MIS)
        rd_d[EW-1:0] = ris_q & imr_q;
    else if (I_PADDR == `DHT_OFF_ADC)
        rd_d[EW-1:0] = adc_q;
end

always @(posedge I_REF_CLK)
begin
    if (I_RST)
    begin
        cfg_q <= `DHT_RST_CFG;
        mode_a_q <= `DHT_RST_MODE;
        mode_b_q <= `DHT_RST_MODE;
        ctl_q <= 2'h0;
        load_a_q <= {HALF_W{1'b0}};
        load_b_q <= {HALF_W{1'b0}};
        match_a_q <= {HALF_W{1'b0}};
        match_b_q <= {HALF_W{1'b0}};
        pre_a_q <= {PW{1'b0}};
        pre_b_q <= {PW{1'b0}};
        ris_q <= `DHT_RST_EV;
        imr_q <= `DHT_RST_EV;
        adc_q <= `DHT_RST_EV;
        rd_clr_q <= `DHT_RST_EV;
        O_PRDATA <= 32'h00000000;
        O_SYNC <= 1'b0;
        O_TRIG_A <= 1'b0;
        O_TRIG_B <= 1'b0;
        O_ADC_TRIG <= 1'b0;
        osc_prev_q <= 1'b0;
        rtc_prev_q <= 1'b0;
        rtc_div_q <= 32'h00000000;
    end
    else
    begin
        osc_prev_q <= I_OSC_CLK;
        rtc_prev_q <= I_RTC_CLK;
        if (!rtc)
            rtc_div_q <= 32'h00000000;
        else if (rtc_edge)
            rtc_div_q <= rtc_sec ? 32'h00000000 : rtc_div_q + 1'b1;
        // Read data is latched in the setup cycle; a read clears only
        // the status bits it returned, so a later event is kept.
        if (rd_setup)
        begin
            O_PRDATA <= rd_d;
            rd_clr_q <= (I_PADDR == `DHT_OFF_RIS) ? ris_q : `DHT_RST_EV;
        end
        ris_q <= (ris_q & ~clr) | ev;
        O_TRIG_A <= a_to & mode_a_q[`DHT_M_TRIG];
        O_TRIG_B <= b_to & mode_b_q[`DHT_M_TRIG];
        O_ADC_TRIG <= |(ev & adc_q);
        O_SYNC <= wr && (I_PADDR == `DHT_OFF_SYNC) && I_PWDATA[0];
        if (wr)
        begin
            if (I_PADDR == `DHT_OFF_CFG)
                cfg_q <= I_PWDATA[2:0];
            else if (I_PADDR == `DHT_OFF_MODE_A)
                mode_a_q <= I_PWDATA[11:0];
            else if (I_PADDR == `DHT_OFF_MODE_B)
                mode_b_q <= I_PWDATA[11:0];
            else if (I_PADDR == `DHT_OFF_CTL)
                ctl_q <= I_PWDATA[1:0];
            else if (I_PADDR == `DHT_OFF_LOAD_A)
                load_a_q <= I_PWDATA[HALF_W-1:0];
            else if (I_PADDR == `DHT_OFF_LOAD_B)
                load_b_q <= I_PWDATA[HALF_W-1:0];
            else if (I_PADDR == `DHT_OFF_MATCH_A)
                match_a_q <= I_PWDATA[HALF_W-1:0];
            else if (I_PADDR == `DHT_OFF_MATCH_B)
                match_b_q <= I_PWDATA[HALF_W-1:0];
            else if (I_PADDR == `DHT_OFF_PRE_A)
                pre_a_q <= I_PWDATA[PW-1:0];
            else if (I_PADDR == `DHT_OFF_PRE_B)
                pre_b_q <= I_PWDATA[PW-1:0];
            else if (I_PADDR == `DHT_OFF_IMR)
                imr_q <= I_PWDATA[EW-1:0];
            else if (I_PADDR == `DHT_OFF_ADC)
                adc_q <= I_PWDATA[EW-1:0];
        end
    end
end

endmodule // dht_timer

// ==== test/dht_timer_properties.sv ====
`timescale 1ns/1ps
`include "dht_consts.vh"

module dht_timer_props (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    input wire O_SYNC,
    input wire O_CCP_A_OE,
    input wire O_CCP_B_OE,
    input wire O_TRIG_A,
    input wire O_ADC_TRIG,
    input wire O_IRQ
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking

    wire acc = I_PSEL && I_PENABLE;
    wire bad = (I_PADDR > `DHT_OFF_SYNC) || (I_PADDR[1:0] != 2'h0);

    a_ready_always: assert property (disable iff (I_RST) O_PREADY)
        else $error("ready dropped");
    a_err_access_only: assert property (disable iff (I_RST)
        O_PSLVERR |-> acc) else $error("error outside access");
    a_err_unmapped: assert property (disable iff (I_RST)
        acc && bad |-> O_PSLVERR) else $error("unmapped not refused");
    a_err_mapped: assert property (disable iff (I_RST)
        acc && !bad |-> !O_PSLVERR) else $error("mapped refused");
    a_rdata_holds: assert property (disable iff (I_RST)
        !(I_PSEL && !I_PENABLE) |=> $stable(O_PRDATA))
        else $error("read data moved");
    a_sync_single: assert property (disable iff (I_RST)
        O_SYNC |=> !O_SYNC) else $error("sync pulse too long");
    a_sync_cause: assert property (disable iff (I_RST)
        $rose(O_SYNC) |-> $past(acc && I_PWRITE && I_PWDATA[0]
        && I_PADDR == `DHT_OFF_SYNC)) else $error("sync without write");
    // Reset itself is the antecedent, so this one has no disable condition.
    a_reset_quiet: assert property (I_RST |=> !O_IRQ && !O_SYNC
        && !O_TRIG_A && !O_ADC_TRIG && !O_CCP_A_OE && !O_CCP_B_OE
        && O_PRDATA == 32'h0) else $error("outputs live after reset");

    c_irq: cover property ($rose(O_IRQ));
    c_err: cover property (O_PSLVERR);
    c_sync: cover property (O_SYNC);
    c_pwm: cover property (O_CCP_A_OE);
endmodule // dht_timer_props

bind dht_timer dht_timer_props u_props (.I_REF_CLK(I_REF_CLK),
    .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_SYNC(O_SYNC), .O_CCP_A_OE(O_CCP_A_OE), .O_CCP_B_OE(O_CCP_B_OE),
    .O_TRIG_A(O_TRIG_A), .O_ADC_TRIG(O_ADC_TRIG), .O_IRQ(O_IRQ));

// ==== test/test_dual_half_timer_module.sv ====
`timescale 1ns/1ps
`include "dht_consts.vh"

module test_dual_half_timer_module;
    reg clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, osc = 0, rtc = 0;
    reg halt = 0, capture_compare_pin = 0, se;
    reg [7:0] pa = 8'h00;
    reg [31:0] pd = 32'h0, v;
    wire [31:0] prdata;
    wire pready, perr, osync, ccpa, ccpa_oe, trga, adct, irq;
    integer err_total = 0, tests_run = 0, cyc = 0, i, k, m, p;

    always #5 clk = ~clk;

    // A short one-second divider keeps the calendar test within a few cycles.
    dht_timer #(.RTC_DIV(4)) dut (.I_REF_CLK(clk), .I_RST(rst),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa),
        .I_PWDATA(pd), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(perr), .I_OSC_CLK(osc), .I_RTC_CLK(rtc),
        .I_DBG_HALT(halt), .I_SYNC(1'b0), .O_SYNC(osync), .I_CCP_A(capture_compare_pin),
        .O_CCP_A(ccpa), .O_CCP_A_OE(ccpa_oe), .I_CCP_B(1'b0), .O_CCP_B(),
        .O_CCP_B_OE(), .O_TRIG_A(trga), .O_TRIG_B(), .O_ADC_TRIG(adct),
        .O_IRQ(irq));

    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input [31:0] g, input [31:0] e);
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task xf(input w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        v = prdata;
        se = perr;
        psel <= 0;
        pen <= 0;
    endtask

    task wr(input [7:0] a, input [31:0] d);
        xf(1'b1, a, d);
    endtask

    task rc(input [7:0] a, input [31:0] e);
        xf(1'b0, a, 32'h0);
        chk(v, e);
    endtask

    task cnt(input integer n);
        k = 0;
        m = 0;
        p = 0;
        repeat (n)
        begin
            @(posedge clk);
            k = k + (trga === 1'b1);
            m = m + (adct === 1'b1);
            p = p + (ccpa === 1'b1);
        end
    endtask

    task rtcp(input integer n);
        repeat (n)
        begin
            rtc <= 1;
            repeat (4) @(posedge clk);
            rtc <= 0;
            repeat (4) @(posedge clk);
        end
    endtask

    task done(input string n);
        $display("test %0s done", n);
    endtask

    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            end_sim;
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 0;
        rc(`DHT_OFF_CFG, 32'h0);
        rc(`DHT_OFF_MODE_A, 32'h0);
        rc(`DHT_OFF_RIS, 32'h0);
        rc(8'h44, 32'h0);
        chk(se, 1);
        wr(`DHT_OFF_LOAD_A, 32'hFFFFFFFF);
        rc(`DHT_OFF_LOAD_A, 32'h0000FFFF);
        wr(`DHT_OFF_PRE_A, 32'hFFFFFFFF);
        rc(`DHT_OFF_PRE_A, 32'h000000FF);
        wr(`DHT_OFF_MODE_B, 32'hFFFFFFFF);
        rc(`DHT_OFF_MODE_B, 32'h00000FFF);
        done("access");
        wr(`DHT_OFF_ADC, 32'h1);
        wr(`DHT_OFF_LOAD_A, 32'h3);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`DHT_OFF_CTL, 32'h0);
            wr(`DHT_OFF_CFG, (i == 2) ? 32'h4 : 32'h0);
            wr(`DHT_OFF_PRE_A, (i == 1) ? 32'h1 : 32'h0);
            wr(`DHT_OFF_MODE_A, 32'h181);
            halt <= (i == 3);
            wr(`DHT_OFF_CTL, 32'h1);
            repeat (8) @(posedge clk);
            cnt(40);
            chk(k, (i > 1) ? 0 : (i == 1 ? 5 : 10));
            chk(m, (i > 1) ? 0 : (i == 1 ? 5 : 10));
        end
        halt <= 0;
        done("periodic");
        wr(`DHT_OFF_CTL, 32'h0);
        wr(`DHT_OFF_RIS, 32'h1FF);
        wr(`DHT_OFF_MODE_A, 32'h0);
        wr(`DHT_OFF_LOAD_A, 32'h5);
        wr(`DHT_OFF_IMR, 32'h1);
        wr(`DHT_OFF_CTL, 32'h1);
        k = 0;
        while (irq !== 1'b1 && k < 50)
        begin
            @(posedge clk);
            k = k + 1;
        end
        chk(irq, 1);
        rc(`DHT_OFF_VAL_A, 32'h0);
        repeat (10) @(posedge clk);
        rc(`DHT_OFF_VAL_A, 32'h0);
        rc(`DHT_OFF_MIS, 32'h1);
        xf(1'b0, `DHT_OFF_RIS, 32'h0);
        chk(v[0], 1);
        @(posedge clk);
        chk(irq, 0);
        wr(`DHT_OFF_IMR, 32'h0);
        wr(`DHT_OFF_CTL, 32'h0);
        wr(`DHT_OFF_CTL, 32'h1);
        repeat (20) @(posedge clk);
        chk(irq, 0);
        rc(`DHT_OFF_MIS, 32'h0);
        wr(`DHT_OFF_RIS, 32'h1FF);
        xf(1'b0, `DHT_OFF_RIS, 32'h0);
        chk(v[0], 0);
        done("one-shot");
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(`DHT_OFF_CTL, 32'h0);
            wr(`DHT_OFF_MODE_A, 32'h2 | (i << 4));
            wr(`DHT_OFF_CTL, 32'h1);
            wr(`DHT_OFF_RIS, 32'h1FF);
            capture_compare_pin <= 1;
            repeat (4) @(posedge clk);
            xf(1'b0, `DHT_OFF_RIS, 32'h0);
            chk(v[2], i != 1);
            capture_compare_pin <= 0;
            repeat (4) @(posedge clk);
            xf(1'b0, `DHT_OFF_RIS, 32'h0);
            chk(v[2], i != 0);
        end
        done("capture");
        wr(`DHT_OFF_CTL, 32'h0);
        wr(`DHT_OFF_MODE_A, 32'h3);
        wr(`DHT_OFF_LOAD_A, 32'h7);
        wr(`DHT_OFF_MATCH_A, 32'h5);
        wr(`DHT_OFF_CTL, 32'h1);
        repeat (8) @(posedge clk);
        cnt(16);
        chk(p, 4);
        chk(ccpa_oe, 1);
        wr(`DHT_OFF_MODE_A, 32'h43);
        repeat (8) @(posedge clk);
        cnt(16);
        chk(p, 12);
        done("pwm");
        wr(`DHT_OFF_CTL, 32'h0);
        wr(`DHT_OFF_CFG, 32'h1);
        wr(`DHT_OFF_MODE_A, 32'h0);
        wr(`DHT_OFF_LOAD_A, 32'hFFFF);
        wr(`DHT_OFF_LOAD_B, 32'h1);
        // Enabling does not reload, so a sync pulse sets the start value.
        wr(`DHT_OFF_SYNC, 32'h1);
        wr(`DHT_OFF_CTL, 32'h1);
        repeat (4) @(posedge clk);
        rc(`DHT_OFF_VAL_B, 32'h1);
        wr(`DHT_OFF_CTL, 32'h0);
        wr(`DHT_OFF_CFG, 32'h3);
        wr(`DHT_OFF_SYNC, 32'h1);
        wr(`DHT_OFF_MATCH_A, 32'h2);
        wr(`DHT_OFF_MATCH_B, 32'h0);
        wr(`DHT_OFF_RIS, 32'h1FF);
        wr(`DHT_OFF_CTL, 32'h1);
        // The match is flagged on the step that leaves the match value.
        rtcp(11);
        xf(1'b0, `DHT_OFF_RIS, 32'h0);
        chk(v[8], 0);
        rtcp(1);
        xf(1'b0, `DHT_OFF_RIS, 32'h0);
        chk(v[8], 1);
        done("joined");
        wr(`DHT_OFF_SYNC, 32'h1);
        @(negedge clk);
        chk(osync, 1);
        done("sync");
        end_sim;
    end
endmodule // test_dual_half_timer_module
